// file: design/art_pkg.sv
// Constants for the 8-bit auto-reload PWM timer: register indices, field positions, reset values.
// Assumes a 32-bit AXI4-Lite bus where each register index takes one aligned word (byte address = 4 * index).
package art_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int IDX_W = AXI_ADDR_W - 2;

  // Register indices as printed; byte address is the index times four
  localparam logic [IDX_W-1:0] IDX_DUTY_CH3 = 10'h073;
  localparam logic [IDX_W-1:0] IDX_DUTY_CH2 = 10'h074;
  localparam logic [IDX_W-1:0] IDX_DUTY_CH1 = 10'h075;
  localparam logic [IDX_W-1:0] IDX_DUTY_CH0 = 10'h076;
  localparam logic [IDX_W-1:0] IDX_PWM_CTRL = 10'h077;
  localparam logic [IDX_W-1:0] IDX_TIMER_CSR = 10'h078;
  localparam logic [IDX_W-1:0] IDX_COUNTER = 10'h079;
  localparam logic [IDX_W-1:0] IDX_RELOAD = 10'h07A;
  localparam logic [IDX_W-1:0] IDX_CAP_CSR = 10'h07B;
  localparam logic [IDX_W-1:0] IDX_CAP_CH1 = 10'h07C;
  localparam logic [IDX_W-1:0] IDX_CAP_CH2 = 10'h07D;

  // Timer control/status fields
  localparam int CSR_EXT_CLK_BIT = 7;
  localparam int CSR_DIV_LSB = 4;
  localparam int CSR_DIV_W = 3;
  localparam int CSR_RUN_BIT = 3;
  localparam int CSR_FRL_BIT = 2;
  localparam int CSR_OIE_BIT = 1;
  localparam int CSR_OVF_BIT = 0;

  // PWM control fields
  localparam int PWM_OE_LSB = 4;
  localparam int PWM_POL_LSB = 0;

  // Capture control/status fields
  localparam int CAP_EDGE_LSB = 4;
  localparam int CAP_IE_LSB = 2;
  localparam int CAP_FLAG_LSB = 0;

  // Reset values and counter limits
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [6:0] PRESC_RESET = 7'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/art_pwm_timer.sv
// 8-bit auto-reload timer with 7-bit prescaler, four PWM outputs, overflow flag and two captures.
// Assumes a single 250 MHz clock, AXI4-Lite master on the register side, asynchronous pins.
//
// Function
// - ext_clock_select picks CPU or external clock
// - prescaler divides input by two to divider
// - run enable low freezes prescaler and counter
// - force reload bit always reads zero
// - force reload loads reload value, clears prescaler
// - overflow request only when enabled and flagged
// - overflow sets flag; status read clears it
// - counter readable and writable while running
// - overflow reloads counter from reload register
// - PWM levels track counter every cycle, not set at reload
// - each output enable gates its pin
// - output high at or below compare, polarity inverts
// - polarity change inverts output at once
// - duty register sets second edge per channel
// - capture status upper two bits read zero
// - edge select: zero falling, one rising
// - capture request only when channel enabled
// - capture sets flag; capture register read clears
// - capture latches counter; register is read-only
// - duty copied to compare shadow at overflow
// - further captures blocked until register read
// - counter increments on each prescaler output tick
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns

module art_pwm_timer
  import art_pkg::*;
#(
  parameter int PWM_CH = 4, // PWM channels
  parameter int CAP_CH = 2 // Capture channels
) (
  input wire logic core_clk_in, // 250 MHz clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic [art_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [art_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  input wire logic ext_clock_pin_in, // External prescaler clock pin
  input wire logic [CAP_CH-1:0] capture_in_pin_in, // Capture input pins
  output logic [PWM_CH-1:0] pwm_out_pin_out, // PWM levels
  output logic [PWM_CH-1:0] pwm_out_oe_out, // PWM pin drive enables
  output logic overflow_irq_out, // Overflow interrupt request
  output logic [CAP_CH-1:0] capture_irq_out // Capture interrupt requests
);

  // Bus state
  logic aw_full_reg;
  logic w_full_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic wr_lane_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Timer state
  logic [7:0] tcsr_reg;
  logic overflow_flag_reg;
  logic [7:0] counter_reg;
  logic [7:0] reload_reg;
  logic [6:0] presc_reg;
  logic [7:0] pwm_ctrl_reg;
  logic [7:0] duty_reg [PWM_CH];
  logic [7:0] shadow_reg [PWM_CH];
  logic [PWM_CH-1:0] pwm_level_reg;
  logic [PWM_CH-1:0] pwm_oe_reg;
  logic overflow_irq_reg;
  logic [3:0] cap_ctrl_reg;
  logic [CAP_CH-1:0] capture_flags_reg;
  logic [7:0] capval_reg [CAP_CH];
  logic [CAP_CH-1:0] capture_irq_reg;

  // Pin synchronisers
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic [CAP_CH-1:0] cap_sync1_reg;
  logic [CAP_CH-1:0] cap_sync2_reg;
  logic [CAP_CH-1:0] cap_prev_reg;

  // Combinational helpers
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic wr_en;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic in_tick;
  logic [6:0] div_mask;
  logic cnt_tick;
  logic ovf_tick;
  logic wr_tcsr;
  logic wr_counter;
  logic force_load;
  logic ctr_sw_load;
  logic [CAP_CH-1:0] cap_edge;
  logic [CAP_CH-1:0] cap_rd_clear;

  assign aw_hs = s_axi_awvalid_in & awready_reg;
  assign w_hs = s_axi_wvalid_in & wready_reg;
  assign ar_hs = s_axi_arvalid_in & arready_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_en = do_write & wr_lane_reg;
  assign rd_idx = s_axi_araddr_in[AXI_ADDR_W-1:2];

  // Write channel: address and data taken in either order, one write in flight
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= REG_RESET;
      wr_lane_reg <= 1'b0;
    end else begin
      aw_full_reg <= (aw_full_reg | aw_hs) & ~do_write;
      w_full_reg <= (w_full_reg | w_hs) & ~do_write;
      awready_reg <= ~((aw_full_reg | aw_hs) & ~do_write);
      wready_reg <= ~((w_full_reg | w_hs) & ~do_write);
      if (aw_hs) begin
        wr_idx_reg <= s_axi_awaddr_in[AXI_ADDR_W-1:2];
      end
      if (w_hs) begin
        wr_data_reg <= s_axi_wdata_in[7:0];
        wr_lane_reg <= s_axi_wstrb_in[0]; // Only lane 0 carries register bits
      end
    end
  end

  // Write response; unmapped indices answer SLVERR
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_idx_reg >= IDX_DUTY_CH3 && wr_idx_reg <= IDX_CAP_CH2) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read mux, looked up at the address handshake
  always_comb begin
    rd_byte = REG_RESET;
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_DUTY_CH3: rd_byte = duty_reg[3];
      IDX_DUTY_CH2: rd_byte = duty_reg[2];
      IDX_DUTY_CH1: rd_byte = duty_reg[1];
      IDX_DUTY_CH0: rd_byte = duty_reg[0];
      IDX_PWM_CTRL: rd_byte = pwm_ctrl_reg;
      IDX_TIMER_CSR: rd_byte = {tcsr_reg[7:3], 1'b0, tcsr_reg[CSR_OIE_BIT], overflow_flag_reg};
      IDX_COUNTER: rd_byte = counter_reg;
      IDX_RELOAD: rd_byte = reload_reg;
      IDX_CAP_CSR: rd_byte = {2'b00, cap_ctrl_reg, capture_flags_reg};
      IDX_CAP_CH1: rd_byte = capval_reg[0];
      IDX_CAP_CH2: rd_byte = capval_reg[1];
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, data one cycle after the handshake
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= ~(ar_hs | (rvalid_reg & ~s_axi_rready_in));
      rvalid_reg <= ar_hs | (rvalid_reg & ~s_axi_rready_in);
      if (ar_hs) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software writes to control registers; force reload bit is never stored
  assign wr_tcsr = wr_en && wr_idx_reg == IDX_TIMER_CSR;
  assign wr_counter = wr_en && wr_idx_reg == IDX_COUNTER;
  assign force_load = wr_tcsr & wr_data_reg[CSR_FRL_BIT];
  assign ctr_sw_load = force_load | wr_counter;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      tcsr_reg <= REG_RESET;
      reload_reg <= REG_RESET;
      pwm_ctrl_reg <= REG_RESET;
      cap_ctrl_reg <= 4'h0;
    end else if (wr_en) begin
      if (wr_idx_reg == IDX_TIMER_CSR) begin
        tcsr_reg <= {wr_data_reg[7:3], 1'b0, wr_data_reg[CSR_OIE_BIT], 1'b0};
      end
      if (wr_idx_reg == IDX_RELOAD) begin
        reload_reg <= wr_data_reg;
      end
      if (wr_idx_reg == IDX_PWM_CTRL) begin
        pwm_ctrl_reg <= wr_data_reg;
      end
      if (wr_idx_reg == IDX_CAP_CSR) begin
        cap_ctrl_reg <= wr_data_reg[5:2];
      end
    end
  end

  // External clock pin: two flops, then an edge detector on the second
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_clock_pin_in;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  // Prescaler input tick and tap select; the pin edge limits external rate to half the core clock
  assign in_tick = tcsr_reg[CSR_EXT_CLK_BIT] ? (ext_sync2_reg & ~ext_prev_reg) : 1'b1;
  assign div_mask = 7'((8'h01 << tcsr_reg[CSR_DIV_LSB +: CSR_DIV_W]) - 8'h01);
  assign cnt_tick = tcsr_reg[CSR_RUN_BIT] & in_tick & ((presc_reg & div_mask) == div_mask);
  assign ovf_tick = cnt_tick & ~ctr_sw_load & (counter_reg == CNT_TOP);

  // Prescaler and counter; software loads win over counting
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      presc_reg <= PRESC_RESET;
      counter_reg <= REG_RESET;
    end else if (force_load) begin
      presc_reg <= PRESC_RESET;
      counter_reg <= reload_reg;
    end else if (wr_counter) begin
      presc_reg <= PRESC_RESET;
      counter_reg <= wr_data_reg;
    end else if (tcsr_reg[CSR_RUN_BIT] && in_tick) begin
      presc_reg <= presc_reg + 7'h01;
      if (cnt_tick) begin
        counter_reg <= (counter_reg == CNT_TOP) ? reload_reg : counter_reg + 8'h01;
      end
    end
  end

  // Overflow flag: a new overflow in the clearing read's cycle keeps the flag set
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      overflow_flag_reg <= 1'b0;
      overflow_irq_reg <= 1'b0;
    end else begin
      if (ovf_tick) begin
        overflow_flag_reg <= 1'b1;
      end else if (ar_hs && rd_idx == IDX_TIMER_CSR) begin
        overflow_flag_reg <= 1'b0;
      end
      overflow_irq_reg <= overflow_flag_reg & tcsr_reg[CSR_OIE_BIT];
    end
  end

  // PWM channels: duty register, compare shadow, output level
  for (genvar ch = 0; ch < PWM_CH; ch++) begin : g_pwm
    always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
        duty_reg[ch] <= REG_RESET;
        shadow_reg[ch] <= REG_RESET;
        pwm_level_reg[ch] <= 1'b0;
        pwm_oe_reg[ch] <= 1'b0;
      end else begin
        if (wr_en && wr_idx_reg == IDX_TIMER_CSR - IDX_W'(ch + 2)) begin
          duty_reg[ch] <= wr_data_reg;
        end
        if (ovf_tick) begin
          shadow_reg[ch] <= duty_reg[ch];
        end
        // Level follows counter against shadow, so polarity flips act at once
        pwm_level_reg[ch] <= (counter_reg <= shadow_reg[ch]) ^ pwm_ctrl_reg[PWM_POL_LSB + ch];
        pwm_oe_reg[ch] <= pwm_ctrl_reg[PWM_OE_LSB + ch];
      end
    end
  end

  // Capture channels: synchroniser, edge select, latch with lockout
  for (genvar ch = 0; ch < CAP_CH; ch++) begin : g_cap
    assign cap_edge[ch] = cap_ctrl_reg[CAP_EDGE_LSB - 2 + ch] ? (cap_sync2_reg[ch] & ~cap_prev_reg[ch])
                                                             : (~cap_sync2_reg[ch] & cap_prev_reg[ch]);
    assign cap_rd_clear[ch] = ar_hs && rd_idx == IDX_CAP_CH1 + IDX_W'(ch);

    always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
        cap_sync1_reg[ch] <= 1'b0;
        cap_sync2_reg[ch] <= 1'b0;
        cap_prev_reg[ch] <= 1'b0;
        capture_flags_reg[ch] <= 1'b0;
        capval_reg[ch] <= REG_RESET;
        capture_irq_reg[ch] <= 1'b0;
      end else begin
        cap_sync1_reg[ch] <= capture_in_pin_in[ch];
        cap_sync2_reg[ch] <= cap_sync1_reg[ch];
        cap_prev_reg[ch] <= cap_sync2_reg[ch];
        // A capture in the clearing read's cycle is taken and keeps the flag
        if (cap_edge[ch] && (!capture_flags_reg[ch] || cap_rd_clear[ch])) begin
          capval_reg[ch] <= counter_reg;
          capture_flags_reg[ch] <= 1'b1;
        end else if (cap_rd_clear[ch]) begin
          capture_flags_reg[ch] <= 1'b0;
        end
        capture_irq_reg[ch] <= capture_flags_reg[ch] & cap_ctrl_reg[CAP_IE_LSB - 2 + ch];
      end
    end
  end

  // Outputs straight from flops
  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign pwm_out_pin_out = pwm_level_reg;
  assign pwm_out_oe_out = pwm_oe_reg;
  assign overflow_irq_out = overflow_irq_reg;
  assign capture_irq_out = capture_irq_reg;

  // Checks on the block's own behaviour
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence write_ready_s;
    aw_full_reg && w_full_reg && !bvalid_reg;
  endsequence

  sequence write_done_s;
    ##1 bvalid_reg && !aw_full_reg && !w_full_reg;
  endsequence

  bus_write_done_a: assert property (write_ready_s |-> write_done_s)
    else $error("write not answered next cycle");

  ovf_flag_set_a: assert property (ovf_tick |=> overflow_flag_reg)
    else $error("overflow did not set flag");
  ovf_reload_a: assert property (ovf_tick |=> counter_reg == $past(reload_reg))
    else $error("overflow did not reload counter");
  run_freeze_a: assert property (!tcsr_reg[CSR_RUN_BIT] && !ctr_sw_load |=>
    $stable(counter_reg) && $stable(presc_reg))
    else $error("counter moved while stopped");
  force_load_a: assert property (force_load |=> counter_reg == $past(reload_reg) && presc_reg == PRESC_RESET)
    else $error("force reload missed");
  ovf_irq_a: assert property (overflow_irq_reg |-> $past(overflow_flag_reg && tcsr_reg[CSR_OIE_BIT]))
    else $error("overflow request without flag and enable");
  shadow_hold_a: assert property (!ovf_tick |=> $stable(shadow_reg[0]) && $stable(shadow_reg[3]))
    else $error("compare shadow changed off overflow");
  // Skips the first cycle out of reset, where the level flop still holds its reset value
  pwm_level_a: assert property ($past(rst_b_in) |->
    pwm_level_reg[1] == $past((counter_reg <= shadow_reg[1]) ^ pwm_ctrl_reg[PWM_POL_LSB + 1]))
    else $error("pwm level wrong");
  cap_lockout_a: assert property (capture_flags_reg[0] && !cap_rd_clear[0] |=> $stable(capval_reg[0]))
    else $error("capture overwrote unread value");
  cap_latch_a: assert property (cap_edge[1] && !capture_flags_reg[1] |=>
    capture_flags_reg[1] && capval_reg[1] == $past(counter_reg))
    else $error("capture did not latch counter");
  csr_read_zero_a: assert property (ar_hs && rd_idx == IDX_TIMER_CSR |=> rdata_reg[CSR_FRL_BIT] == 1'b0)
    else $error("force reload bit read as one");

endmodule

// file: verif/art_pin_model.sv
// Far-side model: external clock source, capture signal sources and the PWM pin wires.
// Assumes the bench changes its requests just after a rising core clock edge.
`timescale 1ns/1ns

module art_pin_model #(
  parameter int EXT_HALF = 4 // Core cycles per half period, keeps the clock below core/4
) (
  input wire logic core_clk_in, // Core clock, times the external clock
  input wire logic burst_go_in, // One-cycle request for a burst of edges
  input wire logic [7:0] burst_len_in, // Rising edges per burst
  input wire logic [1:0] cap_level_in, // Levels wanted on the capture sources
  input wire logic [3:0] pwm_level_in, // PWM levels from the timer
  input wire logic [3:0] pwm_oe_in, // PWM drive enables from the timer
  output logic ext_clock_out, // External prescaler clock
  output logic [1:0] capture_out, // Capture signal sources
  output logic [3:0] pwm_wire_out // Pin levels seen on the board
);
  int half_cnt = 0;
  logic [8:0] left = '0;

  // Clock stands low between bursts, so no stray edge is ever counted
  initial ext_clock_out = 1'b0;
  always @(posedge core_clk_in) begin
    if (burst_go_in) begin
      left <= {burst_len_in, 1'b0};
      half_cnt <= 0;
    end else if (left != '0) begin
      if (half_cnt == EXT_HALF - 1) begin
        half_cnt <= 0;
        ext_clock_out <= ~ext_clock_out;
        left <= left - 9'h001;
      end else begin
        half_cnt <= half_cnt + 1;
      end
    end
  end

  // Sources follow the request; undriven PWM pins sit on a pull-down
  assign capture_out = cap_level_in;
  assign pwm_wire_out = pwm_level_in & pwm_oe_in;
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the auto-reload PWM timer: AXI4-Lite tasks and directed tests.
// Assumes the pin model beside it; byte address is four times the register index.
`timescale 1ns/1ns

module tb_top;
  import art_pkg::*;
  localparam int LIMIT = 60000; // Tests need about 9000 cycles
  logic clk = 0;
  logic rst_b = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h1, pwm, oe, wire_lv;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, go = 0;
  logic awr, wr, bv, arr, rv, ext, oirq;
  logic [1:0] bresp, rresp, cap, cirq, caplv = 2'b10;
  logic [7:0] blen = 8'h00, rd;
  int errors = 0, n_checks = 0, cyc = 0, t0;

  art_pwm_timer i_art_pwm_timer (.core_clk_in(clk), .rst_b_in(rst_b), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .ext_clock_pin_in(ext), .capture_in_pin_in(cap), .pwm_out_pin_out(pwm), .pwm_out_oe_out(oe),
    .overflow_irq_out(oirq), .capture_irq_out(cirq));
  art_pin_model i_art_pin_model (.core_clk_in(clk), .burst_go_in(go), .burst_len_in(blen),
    .cap_level_in(caplv), .pwm_level_in(pwm), .pwm_oe_in(oe), .ext_clock_out(ext), .capture_out(cap),
    .pwm_wire_out(wire_lv));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // Hang guard: a run past the ceiling is a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] exp = RESP_OKAY);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) break;
    end
    bready <= 1'b0;
    check(bresp, exp);
  endtask

  task automatic rd_reg(input logic [IDX_W-1:0] idx, output logic [7:0] d, input logic [1:0] exp = RESP_OKAY);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rready <= 1'b0;
    d = rdata[7:0];
    check(rresp, exp);
    check(rdata[31:8], '0);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(idx, v);
    check(v, exp);
  endtask

  // Waits for a fresh rise of the request, so two calls time two overflows exactly
  task automatic wait_ovf();
    int n;
    n = 0;
    while (oirq === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    while (oirq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check(oirq, 1'b1);
  endtask

  // Capture source edge, settled through the pin synchroniser
  task automatic set_cap(input logic [1:0] lv);
    @(posedge clk);
    caplv <= lv;
    repeat (6) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    while (awr !== 1'b1) @(posedge clk);
    for (int i = 0; i < 11; i++) rd_chk(IDX_W'(IDX_DUTY_CH3 + i), 8'h00);
    rd_reg(10'h07E, rd, RESP_SLVERR);
    wr_reg(10'h07E, 8'hFF, RESP_SLVERR);
    // Lane 0 strobe low: the write is answered but must leave the register alone
    wstrb <= 4'h0;
    wr_reg(IDX_DUTY_CH1, 8'h5A);
    wstrb <= 4'h1;
    rd_chk(IDX_DUTY_CH1, 8'h00);
    done("reset");
    wr_reg(IDX_RELOAD, 8'h40);
    wr_reg(IDX_TIMER_CSR, 8'h04);
    rd_chk(IDX_COUNTER, 8'h40);
    rd_chk(IDX_TIMER_CSR, 8'h00);
    repeat (40) @(posedge clk);
    rd_chk(IDX_COUNTER, 8'h40);
    done("reload");
    // Period is 16 ticks of 2^k core cycles for every divider code
    wr_reg(IDX_RELOAD, 8'hF0);
    for (int k = 0; k < 8; k++) begin
      wr_reg(IDX_TIMER_CSR, {1'b0, k[2:0], 4'b1110});
      rd_reg(IDX_TIMER_CSR, rd);
      wait_ovf();
      t0 = cyc;
      rd_chk(IDX_TIMER_CSR, {1'b0, k[2:0], 4'b1011});
      wait_ovf();
      check(cyc - t0, 16 << k);
    end
    rd_chk(IDX_COUNTER, 8'hF0);
    rd_chk(IDX_TIMER_CSR, 8'h7B);
    rd_chk(IDX_TIMER_CSR, 8'h7A);
    check(oirq, 1'b0);
    wr_reg(IDX_TIMER_CSR, 8'h08);
    repeat (40) @(posedge clk);
    check(oirq, 1'b0);
    rd_chk(IDX_TIMER_CSR, 8'h09);
    done("divider");
    // Shadow stays old until an overflow copies the duty value
    wr_reg(IDX_TIMER_CSR, 8'h00);
    wr_reg(IDX_DUTY_CH0, 8'hF8);
    wr_reg(IDX_COUNTER, 8'hF8);
    repeat (2) @(posedge clk);
    check(pwm, 4'h0);
    wr_reg(IDX_PWM_CTRL, 8'h10);
    wr_reg(IDX_COUNTER, 8'hFF);
    rd_reg(IDX_TIMER_CSR, rd);
    wr_reg(IDX_TIMER_CSR, 8'h0A);
    wait_ovf();
    wr_reg(IDX_TIMER_CSR, 8'h00);
    wr_reg(IDX_COUNTER, 8'hF8);
    repeat (2) @(posedge clk);
    check(pwm, 4'h1);
    check(oe, 4'h1);
    check(wire_lv, 4'h1);
    wr_reg(IDX_COUNTER, 8'hF9);
    repeat (2) @(posedge clk);
    check(pwm, 4'h0);
    wr_reg(IDX_PWM_CTRL, 8'hA5);
    @(posedge clk);
    check(pwm, 4'h5);
    check(oe, 4'hA);
    check(wire_lv, 4'h0);
    wr_reg(IDX_TIMER_CSR, 8'h78);
    wr_reg(IDX_COUNTER, 8'h20);
    rd_chk(IDX_COUNTER, 8'h20);
    done("pwm");
    // Channel 1 rising with request enabled, channel 2 falling without
    wr_reg(IDX_TIMER_CSR, 8'h00);
    wr_reg(IDX_COUNTER, 8'h55);
    wr_reg(IDX_CAP_CSR, 8'h14);
    set_cap(2'b01);
    check(cirq, 2'b01);
    rd_chk(IDX_CAP_CSR, 8'h17);
    wr_reg(IDX_COUNTER, 8'h66);
    set_cap(2'b00);
    set_cap(2'b01);
    rd_chk(IDX_CAP_CH1, 8'h55);
    rd_chk(IDX_CAP_CSR, 8'h16);
    check(cirq, 2'b00);
    set_cap(2'b00);
    wr_reg(IDX_COUNTER, 8'h77);
    set_cap(2'b01);
    rd_chk(IDX_CAP_CH1, 8'h77);
    rd_chk(IDX_CAP_CH2, 8'h55);
    wr_reg(IDX_CAP_CSR, 8'hFF);
    rd_chk(IDX_CAP_CSR, 8'h3C);
    done("capture");
    // External source: core cycles must not count, each rising pin edge must
    wr_reg(IDX_TIMER_CSR, 8'h80);
    wr_reg(IDX_COUNTER, 8'h00);
    wr_reg(IDX_TIMER_CSR, 8'h88);
    repeat (40) @(posedge clk);
    rd_chk(IDX_COUNTER, 8'h00);
    @(posedge clk);
    blen <= 8'h05;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (60) @(posedge clk);
    rd_chk(IDX_COUNTER, 8'h05);
    done("external clock");
    give_verdict();
  end
endmodule
